// ### rtl/pm_regs.svh
// What this block does
// - highest enabled peripheral alone controls pin
// - analog inputs connect only in analog mode
// - digital outputs still win in analog mode
// - pin level always reaches input functions
// - overriding inputs hold their rank, pin undriven
// - port A pins 0-3 fixed priority order
// - port A pin 4 fixed priority order
// - port A pin 6 fixed priority order
// - port A pin 7 fixed priority order
// - port B pins 0,1,3,4,5 priority order
// - port B pin 2 fixed priority order
// - port B pin 6 fixed priority order
// - port B pin 7 fixed priority order
// - A5 never drives; pull-up forced by master clear
// - alternate-pin selects move functions between pins
// - larger-variant functions absent on small variant
`ifndef PM_REGS_SVH
`define PM_REGS_SVH

// reset values of the pin drivers
`define PM_RST_OUT 16'h0000
`define PM_RST_OE_N 16'hFFFF
`define PM_RST_PULLUP 8'h00

// pins that own an analog-select bit
`define PM_ANALOG_MASK_A 8'h1F
`define PM_ANALOG_MASK_B 8'hFE

// position of the input-only pin on port A
`define PM_INPUT_ONLY_PIN 5

`endif

// ### rtl/pm_pkg.sv
`default_nettype none
package pm_pkg;

  // one candidate driver of a pin
  typedef struct packed {
    logic en;   // claims the pin
    logic val;  // level to drive
    logic oe;   // 1 when the pin is actually driven
  } pm_src_s;

  // every peripheral output that can claim a pin
  typedef struct packed {
    pm_src_s serial_data_out_2;
    pm_src_s slave_select_2;
    pm_src_s dac_output;
    pm_src_s sr_latch_q;
    pm_src_s sr_latch_q_inverted;
    pm_src_s capture_compare_1;
    pm_src_s capture_compare_2;
    pm_src_s capture_compare_3;
    pm_src_s capture_compare_4;
    pm_src_s comparator1_output;
    pm_src_s comparator2_output;
    pm_src_s timer0_clock_input;
    pm_src_s oscillator_output;
    pm_src_s oscillator_clock_input;
    pm_src_s instruction_clock_out;
    pm_src_s reference_clock_out;
    pm_src_s serial_data_out_1;
    pm_src_s pwm1_output_a;
    pm_src_s pwm1_output_b;
    pm_src_s pwm1_output_c;
    pm_src_s pwm1_output_d;
    pm_src_s pwm2_output_a;
    pm_src_s pwm2_output_b;
    pm_src_s i2c_data_1;
    pm_src_s i2c_data_2;
    pm_src_s i2c_clock_1;
    pm_src_s i2c_clock_2;
    pm_src_s spi_clock_1;
    pm_src_s spi_clock_2;
    pm_src_s serial_transmit_or_clock;
    pm_src_s serial_receive_or_data;
    pm_src_s modulator_output;
    pm_src_s programming_clock;
    pm_src_s programming_data;
    pm_src_s timer1_osc_input;
    pm_src_s timer1_osc_output;
  } pm_periph_s;

  // alternate-pin selects, 1 moves the function off its default pin
  typedef struct packed {
    logic rx_alt;    // receive/data: port B 1 -> port B 2
    logic tx_alt;    // transmit/clock: port B 2 -> port B 5
    logic serial_data_out_1_alt;  // serial data out 1: port B 2 -> port A 6
    logic capture_compare_1_alt;  // capture 1 / pwm1 A: port B 3 -> port B 0
    logic p1c_alt;   // pwm1 C: port B 6 -> port A 7
    logic p1d_alt;   // pwm1 D: port B 7 -> port A 6
    logic capture_compare_2_alt;  // capture 2: port B 6 -> port A 7
    logic p2a_alt;   // pwm2 A: port B 6 -> port A 7
    logic p2b_alt;   // pwm2 B: port B 7 -> port A 6
  } pm_alt_s;

endpackage : pm_pkg
`default_nettype wire

// ### rtl/pm_pin_sync.sv
`default_nettype none
module pm_pin_sync #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // raw pin levels and filtered result
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // three-stage capture chain
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change is accepted once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & q);
    end
  end

endmodule : pm_pin_sync
`default_nettype wire

// ### rtl/pm_prio_sel.sv
`default_nettype none
module pm_prio_sel #(
  parameter int N = 2
) (
  // candidates, index N-1 highest, index 0 the port latch
  input wire pm_pkg::pm_src_s [N-1:0] src,
  // chosen driver
  output var pm_pkg::pm_src_s win,
  output logic periph_win
);

  // later (higher) enabled entries overwrite lower ones
  always_comb begin
    win = src[0];
    periph_win = 1'b0;
    for (int i = 1; i < N; i++) begin
      if (src[i].en) begin
        win = src[i];
        periph_win = 1'b1;
      end
    end
  end

endmodule : pm_prio_sel
`default_nettype wire

// ### rtl/pm_port_output_priority_mux.sv
`include "pm_regs.svh"
`default_nettype none
module pm_port_output_priority_mux #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // port data latches
  input wire logic [7:0] port_a_latch,
  input wire logic [7:0] port_b_latch,
  // direction, 1 = input
  input wire logic [7:0] port_a_dir_in,
  input wire logic [7:0] port_b_dir_in,
  // analog select per pin
  input wire logic [7:0] analog_select_a,
  input wire logic [7:0] analog_select_b,
  // peripheral outputs and pin relocation
  input wire pm_pkg::pm_periph_s periph,
  input wire pm_pkg::pm_alt_s alt_sel,
  // configuration word and pull-up controls
  input wire logic osc_out_cfg,
  input wire logic osc_in_cfg,
  input wire logic master_clear_enable,
  input wire logic pullup_user_a5,
  input wire logic [7:0] pullup_user_b,
  // package pins
  input wire logic [7:0] pin_a_in,
  input wire logic [7:0] pin_b_in,
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_a_oe_n,
  output logic [7:0] pin_b_out,
  output logic [7:0] pin_b_oe_n,
  output logic pin_a5_pullup,
  output logic [7:0] pin_b_pullup,
  // toward the peripherals
  output logic [7:0] level_a,
  output logic [7:0] level_b,
  output logic [7:0] analog_conn_a,
  output logic [7:0] analog_conn_b,
  output logic [15:0] periph_owns
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // candidate that only counts when its pin currently hosts it
  function automatic pm_pkg::pm_src_s here(input pm_pkg::pm_src_s s,
                                           input logic ok);
    pm_pkg::pm_src_s r;
    r = s;
    r.en = s.en & ok;
    return r;
  endfunction : here

  // the port latch, always enabled, lowest rank
  function automatic pm_pkg::pm_src_s latch(input logic v,
                                            input logic dir_in);
    pm_pkg::pm_src_s r;
    r.en = 1'b1;
    r.val = v;
    r.oe = ~dir_in;
    return r;
  endfunction : latch

  ////////////////////////////////////////////////////////////////////////
  // variant trimming

  pm_pkg::pm_periph_s g;
  pm_pkg::pm_src_s cp1;
  pm_pkg::pm_src_s [15:0] lat;
  pm_pkg::pm_src_s [15:0] win;
  logic [15:0] own;
  logic [15:0] lat_dir;
  logic [15:0] lat_val;

  // small variant drops the second serial port, capture_compare_2-4 and pwm2
  always_comb begin
    g = periph;
    if (!LARGE_VARIANT) begin
      g.serial_data_out_2.en = 1'b0;
      g.slave_select_2.en = 1'b0;
      g.capture_compare_2.en = 1'b0;
      g.capture_compare_3.en = 1'b0;
      g.capture_compare_4.en = 1'b0;
      g.pwm2_output_a.en = 1'b0;
      g.pwm2_output_b.en = 1'b0;
      g.i2c_data_2.en = 1'b0;
      g.i2c_clock_2.en = 1'b0;
      g.spi_clock_2.en = 1'b0;
    end
  end

  // capture 1 and pwm1 A share one slot; capture wins inside it
  always_comb begin
    cp1 = g.capture_compare_1.en ? g.capture_compare_1 : g.pwm1_output_a;
  end

  ////////////////////////////////////////////////////////////////////////
  // port latch candidates

  assign lat_dir = {port_b_dir_in, port_a_dir_in};
  assign lat_val = {port_b_latch, port_a_latch};

  // one latch entry per pin
  for (genvar i = 0; i < 16; i++) begin : g_lat
    assign lat[i] = latch(lat_val[i], lat_dir[i]);
  end

  ////////////////////////////////////////////////////////////////////////
  // port A resolvers

  // pin 0: serial data out 2
  pm_prio_sel #(.N(2)) u_a0 (
    .src({g.serial_data_out_2, lat[0]}),
    .win(win[0]),
    .periph_win(own[0])
  );

  // pin 1: slave select 2
  pm_prio_sel #(.N(2)) u_a1 (
    .src({g.slave_select_2, lat[1]}),
    .win(win[1]),
    .periph_win(own[1])
  );

  // pin 2: dac output
  pm_prio_sel #(.N(2)) u_a2 (
    .src({g.dac_output, lat[2]}),
    .win(win[2]),
    .periph_win(own[2])
  );

  // pin 3: sr latch, capture 3, comparator 1
  pm_prio_sel #(.N(4)) u_a3 (
    .src({g.sr_latch_q, g.capture_compare_3,
          g.comparator1_output, lat[3]}),
    .win(win[3]),
    .periph_win(own[3])
  );

  // pin 4: timer0 clock input ranks as an overriding input
  pm_prio_sel #(.N(5)) u_a4 (
    .src({g.sr_latch_q_inverted, g.capture_compare_4,
          g.timer0_clock_input, g.comparator2_output, lat[4]}),
    .win(win[4]),
    .periph_win(own[4])
  );

  // pin 5 is input only: never driven
  assign win[5] = '{en: 1'b1, val: 1'b0, oe: 1'b0};
  assign own[5] = 1'b0;

  // pin 6: oscillator output gated by the configuration word
  pm_prio_sel #(.N(7)) u_a6 (
    .src({here(g.oscillator_output, osc_out_cfg),
          g.instruction_clock_out, g.reference_clock_out,
          here(g.serial_data_out_1, alt_sel.serial_data_out_1_alt),
          here(g.pwm1_output_d, alt_sel.p1d_alt),
          here(g.pwm2_output_b, alt_sel.p2b_alt),
          lat[6]}),
    .win(win[6]),
    .periph_win(own[6])
  );

  // pin 7: oscillator input gated by the configuration word
  pm_prio_sel #(.N(5)) u_a7 (
    .src({here(g.oscillator_clock_input, osc_in_cfg),
          here(g.pwm1_output_c, alt_sel.p1c_alt),
          here(g.capture_compare_2, alt_sel.capture_compare_2_alt),
          here(g.pwm2_output_a, alt_sel.p2a_alt),
          lat[7]}),
    .win(win[7]),
    .periph_win(own[7])
  );

  ////////////////////////////////////////////////////////////////////////
  // port B resolvers

  // pin 0: pwm1 A at its alternate home
  pm_prio_sel #(.N(2)) u_b0 (
    .src({here(cp1, alt_sel.capture_compare_1_alt), lat[8]}),
    .win(win[8]),
    .periph_win(own[8])
  );

  // pin 1: i2c data 1, then receive/data at its default home
  pm_prio_sel #(.N(3)) u_b1 (
    .src({g.i2c_data_1,
          here(g.serial_receive_or_data, ~alt_sel.rx_alt),
          lat[9]}),
    .win(win[9]),
    .periph_win(own[9])
  );

  // pin 2: i2c data 2, then three relocatable serial functions
  pm_prio_sel #(.N(5)) u_b2 (
    .src({g.i2c_data_2,
          here(g.serial_transmit_or_clock, ~alt_sel.tx_alt),
          here(g.serial_receive_or_data, alt_sel.rx_alt),
          here(g.serial_data_out_1, ~alt_sel.serial_data_out_1_alt),
          lat[10]}),
    .win(win[10]),
    .periph_win(own[10])
  );

  // pin 3: modulator, then capture 1 / pwm1 A at default home
  pm_prio_sel #(.N(3)) u_b3 (
    .src({g.modulator_output, here(cp1, ~alt_sel.capture_compare_1_alt),
          lat[11]}),
    .win(win[11]),
    .periph_win(own[11])
  );

  // pin 4: i2c clock 1, spi clock 1
  pm_prio_sel #(.N(3)) u_b4 (
    .src({g.i2c_clock_1, g.spi_clock_1, lat[12]}),
    .win(win[12]),
    .periph_win(own[12])
  );

  // pin 5: i2c clock 2, relocated transmit, spi clock 2, pwm1 B
  pm_prio_sel #(.N(5)) u_b5 (
    .src({g.i2c_clock_2,
          here(g.serial_transmit_or_clock, alt_sel.tx_alt),
          g.spi_clock_2, g.pwm1_output_b, lat[13]}),
    .win(win[13]),
    .periph_win(own[13])
  );

  // pin 6: programming clock outranks everything
  pm_prio_sel #(.N(6)) u_b6 (
    .src({g.programming_clock, g.timer1_osc_input,
          here(g.pwm1_output_c, ~alt_sel.p1c_alt),
          here(g.capture_compare_2, ~alt_sel.capture_compare_2_alt),
          here(g.pwm2_output_a, ~alt_sel.p2a_alt),
          lat[14]}),
    .win(win[14]),
    .periph_win(own[14])
  );

  // pin 7: programming data outranks everything
  pm_prio_sel #(.N(5)) u_b7 (
    .src({g.programming_data, g.timer1_osc_output,
          here(g.pwm1_output_d, ~alt_sel.p1d_alt),
          here(g.pwm2_output_b, ~alt_sel.p2b_alt),
          lat[15]}),
    .win(win[15]),
    .periph_win(own[15])
  );

  ////////////////////////////////////////////////////////////////////////
  // pin drivers

  localparam logic [15:0] RST_OUT = `PM_RST_OUT;
  logic [15:0] out_q;
  logic [15:0] oe_n_q;
  logic [15:0] own_q;

  // winner drives regardless of analog mode
  for (genvar i = 0; i < 16; i++) begin : g_drv
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        out_q[i] <= RST_OUT[i];
        oe_n_q[i] <= 1'b1;
        own_q[i] <= 1'b0;
      end else begin
        out_q[i] <= win[i].val;
        oe_n_q[i] <= ~win[i].oe;
        own_q[i] <= own[i];
      end
    end
  end

  assign pin_a_out = out_q[7:0];
  assign pin_a_oe_n = oe_n_q[7:0];
  assign pin_b_out = out_q[15:8];
  assign pin_b_oe_n = oe_n_q[15:8];
  assign periph_owns = own_q;

  ////////////////////////////////////////////////////////////////////////
  // pull-ups

  // master clear forces the pull-up on its pin
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_a5_pullup <= 1'b0;
    end else begin
      pin_a5_pullup <= master_clear_enable | pullup_user_a5;
    end
  end

  // port B weak pull-ups drop while the pin is driven
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_b_pullup <= `PM_RST_PULLUP;
    end else begin
      pin_b_pullup <= pullup_user_b & ~{win[15].oe, win[14].oe,
        win[13].oe, win[12].oe, win[11].oe, win[10].oe,
        win[9].oe, win[8].oe};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input side

  // analog inputs join the pin only in analog mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      analog_conn_a <= 8'h00;
      analog_conn_b <= 8'h00;
    end else begin
      analog_conn_a <= analog_select_a & `PM_ANALOG_MASK_A;
      analog_conn_b <= analog_select_b & `PM_ANALOG_MASK_B;
    end
  end

  // pin levels reach input functions whatever the direction
  pm_pin_sync #(.W(16)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .d({pin_b_in, pin_a_in}),
    .q({level_b, level_a})
  );

endmodule : pm_port_output_priority_mux
`default_nettype wire

// ### tb/pm_mux_props.sv
`default_nettype none
module pm_mux_props #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // controls
  input wire logic [7:0] port_a_latch,
  input wire logic [7:0] port_a_dir_in,
  input wire logic [7:0] analog_select_a,
  input wire pm_pkg::pm_periph_s periph,
  input wire logic master_clear_enable,
  input wire logic pullup_user_a5,
  // pins and results
  input wire logic [7:0] pin_b_in,
  input wire logic [7:0] pin_a_out,
  input wire logic [7:0] pin_a_oe_n,
  input wire logic pin_a5_pullup,
  input wire logic [7:0] level_b,
  input wire logic [7:0] analog_conn_a,
  input wire logic [15:0] periph_owns
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////
  // pin held long enough to pass the input filter
  sequence pin_steady;
    $stable(pin_b_in) [*5];
  endsequence
  // dac output claims and drives its pin
  sequence dac_drives;
    periph.dac_output.en && periph.dac_output.oe;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a5_no_drive_a: assert property (pin_a_oe_n[5])
    else $error("input-only pin driven");
  a5_pull_force_a: assert property (master_clear_enable |=> pin_a5_pullup)
    else $error("pull-up not forced");
  a5_pull_user_a: assert property (!master_clear_enable |=>
    pin_a5_pullup == $past(pullup_user_a5))
    else $error("pull-up ignores user");
  dac_claim_a: assert property (dac_drives |=> !pin_a_oe_n[2] &&
    pin_a_out[2] == $past(periph.dac_output.val) && periph_owns[2])
    else $error("dac lost its pin");
  srq_first_a: assert property (periph.sr_latch_q.en && periph.sr_latch_q.oe
    |=> pin_a_out[3] == $past(periph.sr_latch_q.val) && periph_owns[3])
    else $error("wrong owner on pin a3");
  a0_latch_a: assert property (!(LARGE_VARIANT && periph.serial_data_out_2.en)
    && !port_a_dir_in[0] |=> pin_a_out[0] == $past(port_a_latch[0]) &&
    !pin_a_oe_n[0] && !periph_owns[0])
    else $error("latch lost pin a0");
  analog_map_a: assert property (!$past(reset) |->
    analog_conn_a == ($past(analog_select_a) & 8'h1F))
    else $error("analog link wrong");
  level_follow_a: assert property (pin_steady |-> level_b == pin_b_in)
    else $error("level not followed");
  idle_reset_a: assert property (disable iff (1'b0) reset |=>
    pin_a_oe_n == 8'hFF && periph_owns == 16'h0000)
    else $error("pins driven in reset");
endmodule : pm_mux_props
`default_nettype wire

// ### tb/pm_board.sv
`default_nettype none
module pm_board (
  // clock
  input wire logic ref_clk,
  // device drivers
  input wire logic [7:0] pin_a_out,
  input wire logic [7:0] pin_a_oe_n,
  input wire logic [7:0] pin_b_out,
  input wire logic [7:0] pin_b_oe_n,
  input wire logic pin_a5_pullup,
  input wire logic [7:0] pin_b_pullup,
  // board drivers, enable low
  input wire logic [15:0] ext_val,
  input wire logic [15:0] ext_oe_n,
  // resolved levels
  output logic [7:0] pin_a_in,
  output logic [7:0] pin_b_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] float_q = 16'h0000;
  logic [15:0] lvl, pu, dout, doe_n;
  // floating lines wander so no stale level survives
  always_ff @(posedge ref_clk) begin
    float_q <= ~float_q;
  end
  // pull-ups exist on port A pin 5 and port B only
  assign pu = {pin_b_pullup, 2'b00, pin_a5_pullup, 5'b00000};
  assign dout = {pin_b_out, pin_a_out};
  assign doe_n = {pin_b_oe_n, pin_a_oe_n};
  // drivers clash to unknown, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!doe_n[i] && !ext_oe_n[i]) begin
        lvl[i] = (dout[i] == ext_val[i]) ? dout[i] : 1'bx;
      end else if (!doe_n[i]) begin
        lvl[i] = dout[i];
      end else if (!ext_oe_n[i]) begin
        lvl[i] = ext_val[i];
      end else begin
        lvl[i] = pu[i] | float_q[i];
      end
    end
  end
  assign {pin_b_in, pin_a_in} = lvl;
endmodule : pm_board
`default_nettype wire

// ### tb/pm_port_output_priority_mux_test.sv
`default_nettype none
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("unexpected at %0t got %h exp %h", $time, got, exp); \
  end \
end
module pm_port_output_priority_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic reset = 1'b1;
  logic [7:0] port_a_latch = 8'h00, port_b_latch = 8'h00;
  logic [7:0] port_a_dir_in = 8'hFF, port_b_dir_in = 8'hFF;
  logic [7:0] analog_select_a = 8'h00, analog_select_b = 8'h00;
  logic [7:0] pullup_user_b = 8'h00;
  logic osc_out_cfg = 1'b0, osc_in_cfg = 1'b0;
  logic master_clear_enable = 1'b0, pullup_user_a5 = 1'b0;
  pm_pkg::pm_periph_s periph = '0;
  pm_pkg::pm_alt_s alt_sel = '0;
  logic [15:0] ext_val = 16'h0000, ext_oe_n = 16'hFFFF;
  logic [7:0] pin_a_in, pin_b_in, pin_a_out, pin_a_oe_n, pin_b_out;
  logic [7:0] pin_b_oe_n, pin_b_pullup, level_a, level_b;
  logic [7:0] analog_conn_a, analog_conn_b, s_a_out;
  logic [15:0] periph_owns, s_owns;
  logic pin_a5_pullup;
  int err_count = 0, n_compared = 0, cycles = 0;
  //////////////////////////////////////////////////////////////////////////
  // full and small variants side by side, board on the pins
  pm_port_output_priority_mux u_pm_port_output_priority_mux (
    .ref_clk, .reset, .port_a_latch, .port_b_latch, .port_a_dir_in,
    .port_b_dir_in, .analog_select_a, .analog_select_b, .periph, .alt_sel,
    .osc_out_cfg, .osc_in_cfg, .master_clear_enable, .pullup_user_a5,
    .pullup_user_b, .pin_a_in, .pin_b_in, .pin_a_out, .pin_a_oe_n,
    .pin_b_out, .pin_b_oe_n, .pin_a5_pullup, .pin_b_pullup, .level_a,
    .level_b, .analog_conn_a, .analog_conn_b, .periph_owns
  );
  pm_port_output_priority_mux #(
    .LARGE_VARIANT(1'b0)
  ) u_pm_port_output_priority_mux_small (
    .ref_clk, .reset, .port_a_latch, .port_b_latch, .port_a_dir_in,
    .port_b_dir_in, .analog_select_a, .analog_select_b, .periph, .alt_sel,
    .osc_out_cfg, .osc_in_cfg, .master_clear_enable, .pullup_user_a5,
    .pullup_user_b, .pin_a_in, .pin_b_in, .pin_a_out(s_a_out),
    .pin_a_oe_n(), .pin_b_out(), .pin_b_oe_n(), .pin_a5_pullup(),
    .pin_b_pullup(), .level_a(), .level_b(), .analog_conn_a(),
    .analog_conn_b(), .periph_owns(s_owns)
  );
  pm_board u_pm_board (
    .ref_clk, .pin_a_out, .pin_a_oe_n, .pin_b_out, .pin_b_oe_n,
    .pin_a5_pullup, .pin_b_pullup, .ext_val, .ext_oe_n, .pin_a_in, .pin_b_in
  );
  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      final_report;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // drop all claims, return on an edge ready for new inputs
  task automatic clr;
    @(posedge ref_clk);
    periph <= '0;
    alt_sel <= '0;
    @(posedge ref_clk);
  endtask : clr
  // output registered one edge after the inputs
  task automatic go;
    @(posedge ref_clk);
    #1;
  endtask : go
  // pin a3 owners removed from the top down
  task automatic t_a3;
    clr;
    port_a_dir_in <= 8'h00;
    port_a_latch <= 8'hFF;
    periph.sr_latch_q <= 3'b101;
    periph.capture_compare_3 <= 3'b111;
    periph.comparator1_output <= 3'b101;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      periph.sr_latch_q.en <= (k < 1);
      periph.capture_compare_3.en <= (k < 2);
      periph.comparator1_output.en <= (k < 3);
      go;
      `CHK({pin_a_out[3], periph_owns[3]}, {k[0], k < 3})
    end
  endtask : t_a3
  // pin a6 clock group, oscillator gated by the config word
  task automatic t_a6;
    clr;
    alt_sel.serial_data_out_1_alt <= 1'b1;
    alt_sel.p1d_alt <= 1'b1;
    alt_sel.p2b_alt <= 1'b1;
    periph.oscillator_output <= 3'b111;
    periph.instruction_clock_out <= 3'b101;
    periph.reference_clock_out <= 3'b111;
    periph.serial_data_out_1 <= 3'b101;
    periph.pwm1_output_d <= 3'b111;
    periph.pwm2_output_b <= 3'b101;
    go;
    `CHK(pin_a_out[6], 1'b0)
    for (int k = 0; k < 7; k++) begin
      @(posedge ref_clk);
      osc_out_cfg <= 1'b1;
      periph.oscillator_output.en <= (k < 1);
      periph.instruction_clock_out.en <= (k < 2);
      periph.reference_clock_out.en <= (k < 3);
      periph.serial_data_out_1.en <= (k < 4);
      periph.pwm1_output_d.en <= (k < 5);
      periph.pwm2_output_b.en <= (k < 6);
      go;
      `CHK({pin_a_out[6], periph_owns[6]}, {~k[0], k < 6})
    end
  endtask : t_a6
  // pin b2 with receive moved in; receive leaves the pin undriven
  task automatic t_b2;
    clr;
    port_b_dir_in <= 8'h00;
    alt_sel.rx_alt <= 1'b1;
    periph.i2c_data_2 <= 3'b101;
    periph.serial_transmit_or_clock <= 3'b111;
    periph.serial_receive_or_data <= 3'b100;
    periph.serial_data_out_1 <= 3'b111;
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk);
      periph.i2c_data_2.en <= (k < 1);
      periph.serial_transmit_or_clock.en <= (k < 2);
      periph.serial_receive_or_data.en <= (k < 3);
      periph.serial_data_out_1.en <= (k < 4);
      go;
      `CHK({pin_b_oe_n[2], periph_owns[10]}, {k == 2, k < 4})
      if (k != 2) `CHK(pin_b_out[2], k[0])
    end
  endtask : t_b2
  // capture 2 moved between port B pin 6 and port A pin 7
  task automatic t_alt;
    clr;
    port_a_dir_in <= 8'h00;
    port_a_latch <= 8'h00;
    periph.capture_compare_2 <= 3'b111;
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      alt_sel.capture_compare_2_alt <= k[0];
      go;
      `CHK({pin_a_out[7], periph_owns[7]}, {2{k[0]}})
      `CHK({pin_b_out[6], periph_owns[14]}, {2{~k[0]}})
    end
  endtask : t_alt
  // input-only pin and its pull-up
  task automatic t_a5;
    clr;
    port_a_latch <= 8'hFF;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      master_clear_enable <= k[1];
      pullup_user_a5 <= k[0];
      go;
      `CHK({pin_a5_pullup, pin_a_oe_n[5]}, {k[1] | k[0], 1'b1})
    end
  endtask : t_a5
  // analog mode with a driven pin, levels still reach peripherals
  task automatic t_analog;
    clr;
    analog_select_a <= 8'hFF;
    analog_select_b <= 8'hFF;
    pullup_user_b <= 8'hFF;
    port_b_dir_in <= 8'hFF;
    periph.dac_output <= 3'b111;
    ext_oe_n <= 16'hF7FF;
    go;
    `CHK({analog_conn_b, analog_conn_a}, 16'hFE1F)
    `CHK({pin_a_out[2], pin_a_oe_n[2]}, 2'b10)
    // pin settles one edge late, then four edges of filter
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK({level_b[3], level_a[2]}, 2'b01)
  endtask : t_analog
  // second serial port missing on the small variant
  task automatic t_small;
    clr;
    port_a_latch <= 8'h00;
    periph.serial_data_out_2 <= 3'b111;
    go;
    `CHK({pin_a_out[0], periph_owns[0]}, 2'b11)
    `CHK({s_a_out[0], s_owns[0]}, 2'b00)
  endtask : t_small
  // pin b7 owners removed from the top down
  task automatic t_b7;
    clr;
    port_b_dir_in <= 8'h00;
    port_b_latch <= 8'h00;
    periph.programming_data <= 3'b101;
    periph.timer1_osc_output <= 3'b111;
    periph.pwm1_output_d <= 3'b101;
    periph.pwm2_output_b <= 3'b111;
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk);
      periph.programming_data.en <= (k < 1);
      periph.timer1_osc_output.en <= (k < 2);
      periph.pwm1_output_d.en <= (k < 3);
      periph.pwm2_output_b.en <= (k < 4);
      go;
      `CHK({pin_b_out[7], periph_owns[15]}, {k[0], k < 4})
    end
  endtask : t_b7
  // verdict and end of run
  task automatic final_report;
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_a3;
    t_a6;
    t_b2;
    t_alt;
    t_a5;
    t_analog;
    t_small;
    t_b7;
    final_report;
  end
endmodule : pm_port_output_priority_mux_test
bind pm_port_output_priority_mux pm_mux_props #(
  .LARGE_VARIANT(LARGE_VARIANT)
) u_pm_mux_props (
  .ref_clk, .reset, .port_a_latch, .port_a_dir_in, .analog_select_a,
  .periph, .master_clear_enable, .pullup_user_a5, .pin_b_in, .pin_a_out,
  .pin_a_oe_n, .pin_a5_pullup, .level_b, .analog_conn_a, .periph_owns
);
`default_nettype wire
